// ---- rtl/vic_cfg.svh ----
/*
  vectored interrupt controller: offsets, field positions, reset values and cycle counts.
  assumes a 16-bit register port with an 8-bit word address.
*/
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH

`define VIC_NUM_IRQ       180
`define VIC_FLAG_REGS     12
`define VIC_PRIO_REGS     45
`define VIC_IRQ_SLOTS     192
`define VIC_NUM_TRAPS     6
`define VIC_VEC_OFFSET    8
`define VIC_ADDR_FLAG0    8'h00
`define VIC_ADDR_EN0      8'h10
`define VIC_ADDR_PRIO0    8'h20
`define VIC_ADDR_CTL2     8'h50
`define VIC_ADDR_STATUS   8'h51
`define VIC_CTL2_ALT_BIT  8
`define VIC_CTL2_RST      16'h0000
`define VIC_IVT_START     24'h00_0004
`define VIC_RESET_ADDR    24'h00_0000
`define VIC_PAGE_WORDS    24'h00_0800
`define VIC_USER_CEIL     4'h7
`define VIC_SOFT_SLOT     8'h06
`define VIC_RET_CYC       3'h3
`define VIC_ENTRY_CYC     3

`endif

// ---- rtl/vic_pkg.sv ----
/*
  vectored interrupt controller types: sequencer states and grouped signals.
  assumes vic_cfg.svh is compiled alongside for the numeric constants.
*/
package vic_pkg;

  typedef enum logic [2:0] {VIC_IDLE, VIC_FETCH, VIC_LOAD, VIC_ENTER, VIC_RETURN} vic_state_t;

  typedef struct packed {
    logic [3:0] level;
    logic [7:0] accepted_vector_number;
  } vic_accept_t;

  typedef struct packed {
    logic        boot_segment_defined;
    logic        alt_table_disable_config;
    logic [12:0] boot_segment_limit;
    logic [1:0]  boot_segment_protect;
  } vic_boot_cfg_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } vic_reg_req_t;

endpackage

// ---- rtl/vic_top.sv ----
/*
  vectored interrupt controller: request flags, enables, priority fields, arbitration,
  vector fetch from primary or alternate table and dispatch to the core.
  assumes one 25 MHz clock, synchronous inputs and a program memory answering one cycle
  after its read strobe.
*/
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "vic_cfg.svh"

module vic_top (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire vic_pkg::vic_reg_req_t reg_req,
  output logic [15:0]                reg_rdata,
  input  wire logic [191:0]          irq_line,
  input  wire logic [5:0]            trap_req,
  input  wire vic_pkg::vic_boot_cfg_t boot_cfg,
  input  wire logic [3:0]            cpu_priority_level,
  output logic                       cpu_irq_req,
  input  wire logic                  cpu_ack,
  input  wire logic                  cpu_return,
  output logic [23:0]                vec_fetch_addr,
  output logic                       vec_fetch_rd,
  output logic [1:0]                 vec_fetch_prot,
  input  wire logic [23:0]           vec_fetch_data,
  output logic                       branch_valid,
  output logic [23:0]                branch_addr,
  output logic                       return_done,
  output vic_pkg::vic_accept_t       accepted_request_status
);
  import vic_pkg::*;

  function automatic logic irq_impl(input int n);
    unique case (n)
      0, 1, 2, 3, 7, 8, 9, 10, 11, 12, 13, 15, 16, 17, 18, 19, 20, 29, 57, 65, 73,
      94, 95, 96, 103, 110, 111, 112, 113, 114, 115, 116, 117,
      151, 152, 153, 154, 157, 173, 177, 178, 179: irq_impl = 1'b1;
      default: irq_impl = 1'b0;
    endcase
  endfunction

  function automatic logic [3:0] trap_level(input int j);
    unique case (j)
      0: trap_level = 4'hE;
      1: trap_level = 4'hD;
      2: trap_level = 4'hD;
      3: trap_level = 4'hC;
      4: trap_level = 4'hB;
      default: trap_level = 4'h9;
    endcase
  endfunction

  logic [15:0]   flag_q [`VIC_FLAG_REGS];
  logic [15:0]   en_q [`VIC_FLAG_REGS];
  logic [15:0]   prio_q [`VIC_PRIO_REGS];
  logic [15:0]   ctl2_q;
  logic [191:0]  impl_mask;
  logic [191:0]  flag_all;
  logic [191:0]  en_all;
  logic [2:0]    prio_of [`VIC_NUM_IRQ];
  logic          usr_hit;
  logic [2:0]    usr_lvl;
  logic [7:0]    usr_idx;
  logic          trap_hit;
  logic [3:0]    trap_lvl;
  logic [7:0]    trap_slot;
  logic          win_valid;
  vic_accept_t   win;
  logic          alt_active;
  logic [23:0]   table_base;
  vic_state_t    state_q;
  logic [2:0]    ret_cnt_q;
  logic [15:0]   rdata_d;

  // implemented sources and per-source views of the packed registers
  for (genvar i = 0; i < `VIC_IRQ_SLOTS; i++) begin : g_mask
    assign impl_mask[i] = irq_impl(i);
    assign flag_all[i]  = flag_q[i / 16][i % 16];
    assign en_all[i]    = en_q[i / 16][i % 16];
  end
  for (genvar i = 0; i < `VIC_NUM_IRQ; i++) begin : g_prio
    assign prio_of[i] = prio_q[i / 4][4 * (i % 4) +: 3];
  end

  // flags: hardware set wins over a software write in the same cycle
  for (genvar r = 0; r < `VIC_FLAG_REGS; r++) begin : g_flag
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        flag_q[r] <= '0;
      end else begin
        for (int b = 0; b < 16; b++) begin
          flag_q[r][b] <= impl_mask[16 * r + b] &
            (((reg_req.wr && reg_req.addr == 8'(`VIC_ADDR_FLAG0 + r)) ?
              reg_req.wdata[b] : flag_q[r][b]) | irq_line[16 * r + b]);
        end
      end
    end
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        en_q[r] <= '0;
      end else if (reg_req.wr && reg_req.addr == 8'(`VIC_ADDR_EN0 + r)) begin
        en_q[r] <= reg_req.wdata & impl_mask[16 * r +: 16];
      end
    end
  end

  // priority fields, four 3-bit fields per register
  for (genvar p = 0; p < `VIC_PRIO_REGS; p++) begin : g_prio_reg
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        prio_q[p] <= '0;
      end else if (reg_req.wr && reg_req.addr == 8'(`VIC_ADDR_PRIO0 + p)) begin
        prio_q[p] <= reg_req.wdata & 16'h7777;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl2_q <= `VIC_CTL2_RST;
    end else if (reg_req.wr && reg_req.addr == `VIC_ADDR_CTL2) begin
      ctl2_q <= reg_req.wdata & (16'h0001 << `VIC_CTL2_ALT_BIT);
    end
  end

  // user arbitration: strict compare keeps the lowest index among equal levels
  always_comb begin
    usr_hit = 1'b0;
    usr_lvl = 3'h0;
    usr_idx = 8'h00;
    for (int i = 0; i < `VIC_NUM_IRQ; i++) begin
      if (flag_all[i] && en_all[i] && impl_mask[i] && prio_of[i] > usr_lvl) begin
        usr_hit = 1'b1;
        usr_lvl = prio_of[i];
        usr_idx = 8'(i);
      end
    end
  end

  // traps: first slot above the cpu level wins, no mask
  always_comb begin
    trap_hit  = 1'b0;
    trap_lvl  = 4'h0;
    trap_slot = 8'h00;
    for (int j = `VIC_NUM_TRAPS - 1; j >= 0; j--) begin
      if (trap_req[j] && trap_level(j) > cpu_priority_level) begin
        trap_hit  = 1'b1;
        trap_lvl  = trap_level(j);
        trap_slot = (j == 5) ? `VIC_SOFT_SLOT : 8'(j);
      end
    end
  end

  always_comb begin
    win_valid = 1'b0;
    win       = '0;
    if (trap_hit) begin
      win_valid = 1'b1;
      win       = '{level: trap_lvl, accepted_vector_number: trap_slot};
    end else if (usr_hit && cpu_priority_level < `VIC_USER_CEIL &&
                 {1'b0, usr_lvl} > cpu_priority_level) begin
      win_valid = 1'b1;
      win       = '{level: {1'b0, usr_lvl}, accepted_vector_number: 8'(usr_idx + `VIC_VEC_OFFSET)};
    end
  end

  assign cpu_irq_req = win_valid && state_q == VIC_IDLE;

  // table base: alternate page only under all three conditions
  assign alt_active = boot_cfg.boot_segment_defined && boot_cfg.alt_table_disable_config &&
                      ctl2_q[`VIC_CTL2_ALT_BIT];
  assign table_base = alt_active ?
    24'((24'(boot_cfg.boot_segment_limit) - 24'h00_0001) * `VIC_PAGE_WORDS) : 24'h00_0000;

  // dispatch sequencer, fixed cycle counts for every source
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q   <= VIC_IDLE;
      ret_cnt_q <= '0;
    end else begin
      unique case (state_q)
        VIC_IDLE: begin
          if (cpu_ack && win_valid) begin
            state_q <= VIC_FETCH;
          end else if (cpu_return) begin
            state_q   <= VIC_RETURN;
            ret_cnt_q <= `VIC_RET_CYC;
          end
        end
        VIC_FETCH: state_q <= VIC_LOAD;
        VIC_LOAD: state_q <= VIC_ENTER;
        VIC_ENTER: state_q <= VIC_IDLE;
        VIC_RETURN: begin
          ret_cnt_q <= ret_cnt_q - 3'h1;
          if (ret_cnt_q == 3'h1) begin
            state_q <= VIC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accepted_request_status <= '0;
      vec_fetch_addr          <= '0;
      vec_fetch_rd            <= 1'b0;
    end else begin
      vec_fetch_rd <= 1'b0;
      if (state_q == VIC_IDLE && cpu_ack && win_valid) begin
        accepted_request_status <= win;
        vec_fetch_addr <= table_base + `VIC_IVT_START + {15'h0000, win.accepted_vector_number, 1'b0};
        vec_fetch_rd   <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vec_fetch_prot <= 2'h0;
    end else begin
      vec_fetch_prot <= boot_cfg.boot_segment_protect;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      branch_addr  <= `VIC_RESET_ADDR;
      branch_valid <= 1'b0;
      return_done  <= 1'b0;
    end else begin
      branch_valid <= state_q == VIC_LOAD;
      return_done  <= state_q == VIC_RETURN && ret_cnt_q == 3'h1;
      if (state_q == VIC_LOAD) begin
        branch_addr <= vec_fetch_data;
      end
    end
  end

  // register read port, data one cycle after the strobe
  always_comb begin
    rdata_d = 16'h0000;
    for (int r = 0; r < `VIC_FLAG_REGS; r++) begin
      if (reg_req.addr == 8'(`VIC_ADDR_FLAG0 + r)) rdata_d = flag_q[r];
      if (reg_req.addr == 8'(`VIC_ADDR_EN0 + r)) rdata_d = en_q[r];
    end
    for (int p = 0; p < `VIC_PRIO_REGS; p++) begin
      if (reg_req.addr == 8'(`VIC_ADDR_PRIO0 + p)) rdata_d = prio_q[p];
    end
    if (reg_req.addr == `VIC_ADDR_CTL2) rdata_d = ctl2_q;
    if (reg_req.addr == `VIC_ADDR_STATUS) rdata_d = {4'h0, accepted_request_status};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_req.rd ? rdata_d : 16'h0000;
    end
  end

  a_entry_latency: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == VIC_IDLE && cpu_ack && win_valid) |-> ##3 branch_valid)
    else $error("branch not three cycles after acceptance");
  a_fetch_addr: assert property (@(posedge clk) disable iff (sys_rst)
    vec_fetch_rd |-> vec_fetch_addr ==
      $past(table_base) + 24'h00_0004 + {15'h0000, accepted_request_status.accepted_vector_number, 1'b0})
    else $error("vector fetch address wrong");
  a_branch_data: assert property (@(posedge clk) disable iff (sys_rst)
    branch_valid |-> branch_addr == $past(vec_fetch_data))
    else $error("branch address not the fetched vector");
  a_user_ceiling: assert property (@(posedge clk) disable iff (sys_rst)
    (cpu_irq_req && !trap_hit) |-> cpu_priority_level < 4'h7)
    else $error("user request at cpu level seven");
  a_above_level: assert property (@(posedge clk) disable iff (sys_rst)
    cpu_irq_req |-> win.level > cpu_priority_level)
    else $error("request not above cpu level");
  a_accepted_vector_number_offset: assert property (@(posedge clk) disable iff (sys_rst)
    (cpu_irq_req && !trap_hit) |-> win.accepted_vector_number == usr_idx + 8'h08)
    else $error("vector number not request plus eight");
  a_reserved_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (flag_all & ~impl_mask) == 192'h0)
    else $error("reserved flag set");
  a_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    (irq_line[0] && reg_req.wr && reg_req.addr == 8'h00) |=> flag_q[0][0])
    else $error("flag set lost against clear");
  a_status_latch: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == VIC_IDLE && cpu_ack && win_valid) |=> accepted_request_status == $past(win))
    else $error("accepted status not latched");
  a_alt_base: assert property (@(posedge clk) disable iff (sys_rst)
    !ctl2_q[8] |-> table_base == 24'h00_0000)
    else $error("alternate table without enable");
  a_return_latency: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == VIC_IDLE && cpu_return && !(cpu_ack && win_valid)) |-> ##4 return_done)
    else $error("return latency wrong");

  c_user_dispatch: cover property (@(posedge clk) cpu_ack && cpu_irq_req && !trap_hit);
  c_trap_dispatch: cover property (@(posedge clk) cpu_ack && cpu_irq_req && trap_hit);
  c_alt_table: cover property (@(posedge clk) vec_fetch_rd && alt_active);
  c_return: cover property (@(posedge clk) return_done);

endmodule

// ---- tb/vic_cpu_model.sv ----
/*
  cpu core and vector memory model facing the interrupt controller.
  assumes the controller reads one vector entry per acceptance.
*/
`timescale 1ns/1ps
module vic_cpu_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  gap,
  input  wire logic        cpu_irq_req,
  output logic             cpu_ack,
  input  wire logic        vec_fetch_rd,
  input  wire logic [23:0] vec_fetch_addr,
  output logic [23:0]      vec_fetch_data
);
  logic [7:0] gap_q;

  // accepts a standing request; the gap stands for handler run time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_ack <= 1'b0;
      gap_q   <= 8'h00;
    end else if (cpu_irq_req && gap_q == 8'h00 && !cpu_ack) begin
      cpu_ack <= 1'b1;
      gap_q   <= gap;
    end else begin
      cpu_ack <= 1'b0;
      if (gap_q != 8'h00) begin
        gap_q <= gap_q - 8'h01;
      end
    end
  end

  // every entry, unused ones too, holds a handler address; answered one cycle after the read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vec_fetch_data <= 24'h5A_A5A5;
    end else if (vec_fetch_rd) begin
      vec_fetch_data <= {vec_fetch_addr[11:0], ~vec_fetch_addr[11:0]};
    end else begin
      vec_fetch_data <= ~vec_fetch_data;
    end
  end
endmodule

// ---- tb/vectored_interrupt_controller_test.sv ----
/*
  self-checking bench: register port, arbitration, trap and user dispatch,
  alternate table and return latency.
  assumes vic_cpu_model stands in for the core and program memory.
*/
`timescale 1ns/1ps
`include "vic_cfg.svh"
module vectored_interrupt_controller_test;
  import vic_pkg::*;
  logic          clk, sys_rst, cpu_irq_req, cpu_ack, cpu_return;
  logic          vec_fetch_rd, branch_valid, return_done;
  vic_reg_req_t  reg_req;
  logic [15:0]   reg_rdata;
  logic [191:0]  irq_line;
  logic [5:0]    trap_req;
  vic_boot_cfg_t boot_cfg;
  logic [3:0]    cpu_priority_level, lv;
  logic [23:0]   vec_fetch_addr, vec_fetch_data, branch_addr;
  logic [1:0]    vec_fetch_prot;
  vic_accept_t   accepted_request_status;
  logic [7:0]    gap;
  logic [2:0]    p;
  logic [12:0]   lim;
  int            failures, n_checks, cycles, seed, n;
  int            src[5] = '{0, 1, 3, 11, 96};
  logic [3:0]    tlvl[6] = '{4'hE, 4'hD, 4'hD, 4'hC, 4'hB, 4'h9};
  logic [7:0]    tslot[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06};

  vic_top dut_u (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .irq_line(irq_line), .trap_req(trap_req), .boot_cfg(boot_cfg),
    .cpu_priority_level(cpu_priority_level), .cpu_irq_req(cpu_irq_req), .cpu_ack(cpu_ack),
    .cpu_return(cpu_return), .vec_fetch_addr(vec_fetch_addr), .vec_fetch_rd(vec_fetch_rd),
    .vec_fetch_prot(vec_fetch_prot), .vec_fetch_data(vec_fetch_data),
    .branch_valid(branch_valid), .branch_addr(branch_addr), .return_done(return_done),
    .accepted_request_status(accepted_request_status));
  vic_cpu_model cpu_u (.clk(clk), .sys_rst(sys_rst), .gap(gap), .cpu_irq_req(cpu_irq_req),
    .cpu_ack(cpu_ack), .vec_fetch_rd(vec_fetch_rd), .vec_fetch_addr(vec_fetch_addr),
    .vec_fetch_data(vec_fetch_data));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop();
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("mismatch at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, reg_rdata}, {8'h00, exp}, "read data");
  endtask

  task automatic raise(input logic [191:0] m);
    @(posedge clk);
    irq_line <= m;
    @(posedge clk);
    irq_line <= '0;
  endtask

  task automatic arm(input int s, input logic [2:0] lvl);
    wr(`VIC_ADDR_EN0 + 8'(s / 16), 16'h0001 << (s % 16));
    wr(`VIC_ADDR_PRIO0 + 8'(s / 4), 16'(lvl) << (4 * (s % 4)));
  endtask

  function automatic logic [23:0] exp_fetch(input logic [23:0] b, input logic [7:0] vec);
    return b + `VIC_IVT_START + {15'h0000, vec, 1'b0};
  endfunction

  function automatic logic [23:0] exp_base(input int c, input logic [12:0] lim);
    return (c == 7) ? 24'((24'(lim) - 24'h00_0001) * `VIC_PAGE_WORDS) : 24'h00_0000;
  endfunction

  task automatic expect_go(input logic [7:0] vec, input logic [3:0] lvl, input logic [23:0] b);
    logic [23:0] fa;
    int          k;
    fa = exp_fetch(b, vec);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (cpu_ack !== 1'b1 && k < 60);
    chk({23'h00_0000, cpu_ack}, 24'h00_0001, "acceptance");
    k = 0;
    do begin
      @(posedge clk);
      trap_req <= 6'h00;
      @(negedge clk);
      k++;
    end while (branch_valid !== 1'b1 && k < 8);
    chk(24'(k), 24'(`VIC_ENTRY_CYC), "entry latency");
    chk({12'h000, accepted_request_status}, {12'h000, lvl, vec}, "status");
    chk(vec_fetch_addr, fa, "fetch address");
    chk(branch_addr, {fa[11:0], ~fa[11:0]}, "branch");
    chk({22'h00_0000, vec_fetch_prot}, {22'h00_0000, boot_cfg.boot_segment_protect}, "prot");
  endtask

  task automatic expect_none(input int cyc);
    repeat (cyc) begin
      @(negedge clk);
      chk({23'h00_0000, cpu_irq_req}, 24'h00_0000, "idle request");
    end
  endtask

  initial begin
    int k;
    seed = 28;
    sys_rst = 1'b1;
    reg_req = '0;
    irq_line = '0;
    trap_req = 6'h00;
    boot_cfg = '0;
    cpu_priority_level = 4'h0;
    cpu_return = 1'b0;
    gap = 8'h0C;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk(branch_addr, `VIC_RESET_ADDR, "reset branch");
    rd(`VIC_ADDR_CTL2, `VIC_CTL2_RST);
    wr(`VIC_ADDR_PRIO0, 16'hFFFF);
    rd(`VIC_ADDR_PRIO0, 16'h7777);
    rd(8'hF0, 16'h0000);
    wr(`VIC_ADDR_PRIO0 + 8'h18, 16'h0005);
    rd(`VIC_ADDR_PRIO0 + 8'h18, 16'h0005);
    raise((192'h1 << 96) | 192'h11);
    rd(`VIC_ADDR_FLAG0 + 8'h06, 16'h0001);
    rd(`VIC_ADDR_FLAG0, 16'h0001);
    expect_none(4);
    wr(`VIC_ADDR_FLAG0 + 8'h06, 16'h0000);
    wr(`VIC_ADDR_FLAG0, 16'h0000);
    rd(`VIC_ADDR_FLAG0, 16'h0000);
    // a clear and a set in one cycle: the set must win
    @(posedge clk);
    reg_req  <= '{addr: `VIC_ADDR_FLAG0, wdata: 16'h0000, wr: 1'b1, rd: 1'b0};
    irq_line <= 192'h1;
    @(posedge clk);
    reg_req.wr <= 1'b0;
    irq_line   <= '0;
    rd(`VIC_ADDR_FLAG0, 16'h0001);
    wr(`VIC_ADDR_FLAG0, 16'h0000);
    // equal levels resolve by order, a higher level overrides order
    wr(`VIC_ADDR_PRIO0, 16'h0003);
    wr(`VIC_ADDR_PRIO0 + 8'h02, 16'h3000);
    wr(`VIC_ADDR_EN0, 16'h0801);
    raise(192'h801);
    expect_go(8'h08, 4'h3, 24'h00_0000);
    wr(`VIC_ADDR_FLAG0, 16'h0800);
    expect_go(8'h13, 4'h3, 24'h00_0000);
    rd(`VIC_ADDR_STATUS, 16'h0313);
    wr(`VIC_ADDR_FLAG0, 16'h0000);
    wr(`VIC_ADDR_PRIO0 + 8'h02, 16'h5000);
    raise(192'h801);
    expect_go(8'h13, 4'h5, 24'h00_0000);
    wr(`VIC_ADDR_FLAG0, 16'h0001);
    expect_go(8'h08, 4'h3, 24'h00_0000);
    wr(`VIC_ADDR_FLAG0, 16'h0000);
    @(posedge clk);
    cpu_return <= 1'b1;
    @(negedge clk);
    k = 0;
    do begin
      @(posedge clk);
      cpu_return <= 1'b0;
      @(negedge clk);
      k++;
    end while (return_done !== 1'b1 && k < 10);
    chk(24'(k), 24'h00_0004, "return latency");
    @(posedge clk);
    cpu_priority_level <= `VIC_USER_CEIL;
    arm(1, 3'h7);
    raise(192'h2);
    expect_none(6);
    wr(`VIC_ADDR_FLAG0, 16'h0000);
    for (int i = 0; i < 20; i++) begin
      n = src[$unsigned($random(seed)) % 5];
      p = 3'($random(seed));
      lv = 4'($random(seed)) & 4'h7;
      @(posedge clk);
      gap <= 8'h0C + 8'($unsigned($random(seed)) % 8);
      cpu_priority_level <= lv;
      arm(n, p);
      raise(192'h1 << n);
      if ({1'b0, p} > lv) expect_go(8'(n + 8), {1'b0, p}, 24'h00_0000);
      else expect_none(6);
      wr(`VIC_ADDR_FLAG0 + 8'(n / 16), 16'h0000);
    end
    @(posedge clk);
    cpu_priority_level <= 4'h8;
    trap_req <= 6'h3F;
    expect_go(8'h00, 4'hE, 24'h00_0000);
    for (int t = 0; t < 6; t++) begin
      @(posedge clk);
      trap_req <= 6'h01 << t;
      expect_go(tslot[t], tlvl[t], 24'h00_0000);
    end
    for (int c = 0; c < 8; c++) begin
      lim = 13'h0002 + 13'($unsigned($random(seed)) % 16);
      @(posedge clk);
      boot_cfg <= '{boot_segment_defined: c[0], alt_table_disable_config: c[1],
                    boot_segment_limit: lim, boot_segment_protect: 2'(c)};
      wr(`VIC_ADDR_CTL2, {7'h00, c[2], 8'h00});
      trap_req <= 6'h04;
      expect_go(8'h02, 4'hD, exp_base(c, lim));
    end
    report_and_stop();
  end
endmodule
